// file: core/sfrm_pkg.sv
// Package with register map, fault codes and timing constants for the supply fault reset manager.
//
// Contract
// - Each fault gets its configured response: continue, deglitched off, immediate off, sequenced off; here OV and UV go immediate off unless set to continue.
// - Retry recovers a latched-off channel; shared count selects zero to six or unlimited.
// - After power cycle, restart waits for restart interval and output below decay threshold; here retry waits on the fault's deglitch or toff count.
// - Auxiliary fault pin goes low only for faults selected per channel.
// - Only overvoltage and undervoltage faults may reach the auxiliary fault pin.
// - Reset input held low beyond the hold time puts the device into power-on reset.
// - During power-on reset the device takes no part in serial bus transactions.
// - Rising reset edge after a hold leaves reset and reruns the power-on sequence.
// - Reset input passes a 256 us deglitch filter; shorter pulses are ignored.
// - Output overvoltage or undervoltage disables that channel's converter; here not when the channel's response is continue.
// - Interrupt output asserts on any supported fault or warning.
// - A faulted-off channel triggers a fault-log snapshot write to nonvolatile memory; here not if the fault is gone when a sequenced-off toff count ends.
// - Command registers reload from nonvolatile memory at power-up and on restore request.
// - A fault seen on a shared fault line triggers the configured response.
// - Sequencing delays and shutdowns are timed from the shared sync clock.
// - A programmable watchdog resets the microcontroller when it expires.
// - Time-based, tracking and cascaded sequencing, started by commands or control pins.
// - Register writes are blocked by software or hardware write protection.
// - Shared fault lines are active-low open-drain, driven and read by the device.
// - Hardware write-protect input is active high.
package sfrm_pkg;

  // ----------------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL      = 8'h00;
  localparam logic [7:0] ADDR_RESP      = 8'h04;
  localparam logic [7:0] ADDR_AUXSEL_A  = 8'h08;
  localparam logic [7:0] ADDR_AUXSEL_B  = 8'h0C;
  localparam logic [7:0] ADDR_TOFF      = 8'h10;
  localparam logic [7:0] ADDR_RESTART   = 8'h14;
  localparam logic [7:0] ADDR_DECAY     = 8'h18;
  localparam logic [7:0] ADDR_WDOG      = 8'h1C;
  localparam logic [7:0] ADDR_STATUS    = 8'h20;
  localparam logic [7:0] ADDR_CLEAR     = 8'h24;
  localparam logic [7:0] ADDR_VOUT      = 8'h28;
  localparam logic [7:0] ADDR_TON       = 8'h2C;

  // CTRL fields.
  localparam int CTRL_ON0     = 0;
  localparam int CTRL_ON1     = 1;
  localparam int CTRL_WP      = 2;
  localparam int CTRL_RETRY   = 3;
  localparam int CTRL_RCNT_LO = 4;
  localparam int CTRL_SEQ_LO  = 8;
  localparam int CTRL_RESTORE = 10;
  localparam int CTRL_USEPIN  = 11;

  // Retry count code meaning unlimited retries.
  localparam logic [2:0] RETRY_UNLIMITED = 3'h7;

  // Fault response codes.
  localparam logic [1:0] RESP_CONTINUE = 2'h0;
  localparam logic [1:0] RESP_DEGLITCH = 2'h1;
  localparam logic [1:0] RESP_IMMED    = 2'h2;
  localparam logic [1:0] RESP_SEQOFF   = 2'h3;

  // Sequencing modes.
  localparam logic [1:0] SEQ_TIME    = 2'h0;
  localparam logic [1:0] SEQ_TRACK   = 2'h1;
  localparam logic [1:0] SEQ_CASCADE = 2'h2;

  // Fault source bit positions within a channel's 4-bit fault vector.
  localparam int F_OV    = 0;
  localparam int F_UV    = 1;
  localparam int F_OT    = 2;
  localparam int F_SHARE = 3;
  localparam logic [3:0] AUX_ALLOWED = 4'h3;

  // ----------------------------------------------------------------------
  // Reset values and timing
  // ----------------------------------------------------------------------
  localparam logic [31:0] CTRL_RST     = 32'h0000_0000;
  localparam logic [15:0] WDOG_RST     = 16'h0000;
  localparam logic [15:0] DEGLITCH_RST = 16'h0004;

  localparam int CLK_HZ           = 10_000_000;
  localparam int DEGLITCH_NS      = 256_000;
  localparam int DEGLITCH_CYC     = DEGLITCH_NS / (1_000_000_000 / CLK_HZ);
  localparam int RESET_HOLD_NS    = 2_000_000;
  localparam int RESET_HOLD_CYC   = RESET_HOLD_NS / (1_000_000_000 / CLK_HZ);
  localparam int WDOG_RESET_CYC   = 16;
  localparam int RESTORE_CYC      = 16;

endpackage : sfrm_pkg

// file: core/sfrm_timer.sv
// Down-counter that loads a value and reports when it has run out.
`timescale 1ns/1ps
`default_nettype none
module sfrm_timer
#(
  parameter int W = 16
)
(
  input  wire logic         mclk_i,
  input  wire logic         rst_b_i,
  input  wire logic         load_i,
  input  wire logic [W-1:0] value_i,
  input  wire logic         tick_i,
  output var  logic         done_o
);
  import sfrm_pkg::*;

  logic [W-1:0] cnt_reg;

  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      cnt_reg <= '0;
    else if (load_i)
      cnt_reg <= value_i;
    else if (tick_i && cnt_reg != '0)
      cnt_reg <= cnt_reg - 1'b1;
  end

  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      done_o <= 1'b0;
    else
      done_o <= !load_i && (cnt_reg == '0);
  end
endmodule : sfrm_timer
`default_nettype wire

// file: core/sfrm_top.sv
// Supply fault, retry, sequencing, write protect, reset filter and watchdog manager.
//
// Chosen here: the register addresses and the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module sfrm_top
#(
  parameter int DEGLITCH_CYC_P   = sfrm_pkg::DEGLITCH_CYC,
  parameter int RESET_HOLD_CYC_P = sfrm_pkg::RESET_HOLD_CYC
)
(
  input  wire logic        mclk_i,
  input  wire logic        rst_b_i,
  // AHB-Lite slave.
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output var  logic [31:0] hrdata_o,
  output var  logic        hreadyout_o,
  output var  logic        hresp_o,
  // Supervision inputs, one bit per channel, followed by control, sync and status inputs.
  input  wire logic [1:0]  ov_fault_i,
  input  wire logic [1:0]  uv_fault_i,
  input  wire logic [1:0]  ot_fault_i,
  input  wire logic [1:0]  warn_i,
  input  wire logic        write_protect_i,
  input  wire logic        watchdog_kick_reset_n_i,
  input  wire logic        shared_sync_clock_i,
  input  wire logic        sequence_ctrl_in0_i,
  input  wire logic        sequence_ctrl_in1_i,
  input  wire logic        shared_fault0_n_i,
  input  wire logic        shared_fault1_n_i,
  input  wire logic        nvm_busy_i,
  // Outputs.
  output var  logic [1:0]  converter_en_o,
  output var  logic        power_good_out0_o,
  output var  logic        power_good_out1_o,
  output var  logic        shared_fault0_n_o,
  output var  logic        shared_fault0_n_oe_n_o,
  output var  logic        shared_fault1_n_o,
  output var  logic        shared_fault1_n_oe_n_o,
  output var  logic        aux_fault_out_n_o,
  output var  logic        aux_fault_out_n_oe_n_o,
  output var  logic        irq_out_n_o,
  output var  logic        irq_out_n_oe_n_o,
  output var  logic        mcu_reset_n_o,
  output var  logic        por_active_o,
  output var  logic        serial_bus_enable_o,
  output var  logic        nvm_restore_req_o,
  output var  logic [1:0]  fault_log_req_o
);
  import sfrm_pkg::*;

  typedef enum logic [2:0] {CH_OFF, CH_WAIT, CH_ON, CH_GLITCH, CH_SEQOFF, CH_LATCHED} sfrm_ch_e;

  // ----------------------------------------------------------------------
  // AHB-Lite slave and registers
  // ----------------------------------------------------------------------
  logic [31:0] ctrl_reg;
  logic [31:0] resp_reg;
  logic [3:0]  aux_a_reg, aux_b_reg;
  logic [15:0] toff_reg, ton_reg, restart_reg, wdog_reg;
  logic [31:0] decay_reg;
  logic [31:0] vout_reg;
  logic        wr_pend_reg;
  logic [7:0]  wr_addr_reg;
  logic        rd_pend_reg;
  logic [7:0]  rd_addr_reg;
  logic        por_reg;
  logic        restore_busy_reg;

  wire         bus_live = hsel_i && hready_i && htrans_i[1] && !por_reg;
  wire         wp_on    = ctrl_reg[CTRL_WP] || write_protect_i;
  wire         wr_ok    = wr_pend_reg && (!wp_on || wr_addr_reg == ADDR_CTRL);
  wire         wr_ctrl  = wr_pend_reg && wr_addr_reg == ADDR_CTRL;
  wire         wr_clear = wr_ok && wr_addr_reg == ADDR_CLEAR;
  wire [31:0]  ctrl_wr  = wp_on ? {ctrl_reg[31:3], hwdata_i[CTRL_WP], ctrl_reg[1:0]} : hwdata_i;

  logic [31:0] status_w;
  logic [31:0] rd_mux;
  always_comb
  begin
    unique case (rd_addr_reg)
      ADDR_CTRL:     rd_mux = ctrl_reg;
      ADDR_RESP:     rd_mux = resp_reg;
      ADDR_AUXSEL_A: rd_mux = {28'h0000000, aux_a_reg};
      ADDR_AUXSEL_B: rd_mux = {28'h0000000, aux_b_reg};
      ADDR_TOFF:     rd_mux = {16'h0000, toff_reg};
      ADDR_RESTART:  rd_mux = {16'h0000, restart_reg};
      ADDR_DECAY:    rd_mux = decay_reg;
      ADDR_WDOG:     rd_mux = {16'h0000, wdog_reg};
      ADDR_STATUS:   rd_mux = status_w;
      ADDR_VOUT:     rd_mux = vout_reg;
      ADDR_TON:      rd_mux = {16'h0000, ton_reg};
      default:       rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      rd_addr_reg <= 8'h00;
      hrdata_o    <= 32'h0000_0000;
    end
    else
    begin
      wr_pend_reg <= bus_live && hwrite_i;
      rd_pend_reg <= bus_live && !hwrite_i;
      wr_addr_reg <= haddr_i[7:0];
      rd_addr_reg <= haddr_i[7:0];
      hrdata_o    <= 32'h0000_0000;
      if (rd_pend_reg)
        hrdata_o <= rd_mux;
    end
  end

  // Reads take one wait state so that read data come from a flip-flop.
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
    end
    else
    begin
      hreadyout_o <= !(bus_live && !hwrite_i);
      hresp_o     <= 1'b0;
    end
  end

  // Configuration restore from nonvolatile memory: at power-up, after a
  // power-on reset, or on request. Defaults here stand in for stored values.
  logic restore_go;
  logic [4:0] restore_cnt_reg;
  assign restore_go = wr_ok && wr_ctrl && hwdata_i[CTRL_RESTORE];

  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      ctrl_reg    <= CTRL_RST;
      resp_reg    <= 32'h0000_0000;
      aux_a_reg   <= 4'h0;
      aux_b_reg   <= 4'h0;
      toff_reg    <= 16'h0000;
      ton_reg     <= 16'h0000;
      restart_reg <= 16'h0000;
      decay_reg   <= 32'h0000_0000;
      wdog_reg    <= WDOG_RST;
      vout_reg    <= 32'h0000_0000;
    end
    else if (por_reg || (restore_busy_reg && restore_cnt_reg == 5'h01))
    begin
      ctrl_reg <= {ctrl_reg[31:12], 12'h000};
    end
    else if (wr_pend_reg)
    begin
      if (wr_ctrl)
        ctrl_reg <= {ctrl_wr[31:12], ctrl_wr[CTRL_USEPIN], 1'b0, ctrl_wr[9:0]};
      if (wr_ok)
      begin
        unique case (wr_addr_reg)
          ADDR_RESP:     resp_reg    <= hwdata_i;
          ADDR_AUXSEL_A: aux_a_reg   <= hwdata_i[3:0] & AUX_ALLOWED;
          ADDR_AUXSEL_B: aux_b_reg   <= hwdata_i[3:0] & AUX_ALLOWED;
          ADDR_TOFF:     toff_reg    <= hwdata_i[15:0];
          ADDR_RESTART:  restart_reg <= hwdata_i[15:0];
          ADDR_DECAY:    decay_reg   <= hwdata_i;
          ADDR_WDOG:     wdog_reg    <= hwdata_i[15:0];
          ADDR_VOUT:     vout_reg    <= hwdata_i;
          ADDR_TON:      ton_reg     <= hwdata_i[15:0];
          default:       ;
        endcase
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      restore_busy_reg <= 1'b1;
      restore_cnt_reg  <= 5'(RESTORE_CYC);
    end
    else if (por_reg || restore_go)
    begin
      restore_busy_reg <= 1'b1;
      restore_cnt_reg  <= 5'(RESTORE_CYC);
    end
    else if (restore_busy_reg && !nvm_busy_i)
    begin
      restore_cnt_reg  <= restore_cnt_reg - 5'h01;
      restore_busy_reg <= restore_cnt_reg != 5'h01;
    end
  end

  // ----------------------------------------------------------------------
  // Reset input filter, hold detector and watchdog
  // ----------------------------------------------------------------------
  logic [15:0] glitch_cnt_reg;
  logic        rst_filt_reg;
  logic        rst_filt_d_reg;
  logic [23:0] hold_cnt_reg;
  logic [15:0] wdog_cnt_reg;
  logic [4:0]  mcu_cnt_reg;

  wire kick = rst_filt_reg && !rst_filt_d_reg;

  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      glitch_cnt_reg <= 16'h0000;
      rst_filt_reg   <= 1'b1;
      rst_filt_d_reg <= 1'b1;
    end
    else
    begin
      rst_filt_d_reg <= rst_filt_reg;
      if (watchdog_kick_reset_n_i == rst_filt_reg)
        glitch_cnt_reg <= 16'h0000;
      else if (glitch_cnt_reg == 16'(DEGLITCH_CYC_P - 1))
      begin
        rst_filt_reg   <= watchdog_kick_reset_n_i;
        glitch_cnt_reg <= 16'h0000;
      end
      else
        glitch_cnt_reg <= glitch_cnt_reg + 16'h0001;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      hold_cnt_reg <= 24'h000000;
      por_reg      <= 1'b0;
    end
    else if (!rst_filt_reg)
    begin
      if (hold_cnt_reg == 24'(RESET_HOLD_CYC_P))
        por_reg <= 1'b1;
      else
        hold_cnt_reg <= hold_cnt_reg + 24'h000001;
    end
    else
    begin
      hold_cnt_reg <= 24'h000000;
      por_reg      <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      wdog_cnt_reg <= 16'h0000;
      mcu_cnt_reg  <= 5'h00;
    end
    else
    begin
      if (kick || wdog_reg == 16'h0000 || mcu_cnt_reg != 5'h00)
        wdog_cnt_reg <= 16'h0000;
      else if (wdog_cnt_reg == wdog_reg)
      begin
        wdog_cnt_reg <= 16'h0000;
        mcu_cnt_reg  <= 5'(WDOG_RESET_CYC);
      end
      else
        wdog_cnt_reg <= wdog_cnt_reg + 16'h0001;
      if (mcu_cnt_reg != 5'h00)
        mcu_cnt_reg <= mcu_cnt_reg - 5'h01;
    end
  end

  // ----------------------------------------------------------------------
  // Shared clock tick and channel state machines
  // ----------------------------------------------------------------------
  logic share_d_reg;
  wire  share_tick = shared_sync_clock_i && !share_d_reg;
  wire  [1:0] shared_in = {!shared_fault1_n_i, !shared_fault0_n_i};
  wire  [1:0] ctrl_pin  = {sequence_ctrl_in1_i, sequence_ctrl_in0_i};
  wire  [2:0] rcnt      = ctrl_reg[CTRL_RCNT_LO +: 3];
  wire  [1:0] seq_mode  = ctrl_reg[CTRL_SEQ_LO +: 2];

  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      share_d_reg <= 1'b0;
    else
      share_d_reg <= shared_sync_clock_i;
  end

  sfrm_ch_e   st_reg [2];
  logic [2:0] retry_reg [2];
  logic [1:0] pg_reg;
  logic [1:0] latched;
  logic [1:0] warn_any;
  logic [3:0] fv [2];

  for (genvar c = 0; c < 2; c++)
  begin : g_ch
    wire  [1:0] resp    = resp_reg[c*2 +: 2];
    wire  req_on  = !restore_busy_reg && ctrl_reg[c] && (!ctrl_reg[CTRL_USEPIN] || ctrl_pin[c]);
    wire  prev_ok = (c == 0) || (seq_mode != SEQ_CASCADE) || pg_reg[0];
    wire  decayed = vout_reg[c*16 +: 16] < decay_reg[c*16 +: 16];
    wire  faulty;
    wire  tmr_done;
    wire  tmr_load;
    wire  [15:0] tmr_val;

    assign fv[c]  = {shared_in[c], ot_fault_i[c], uv_fault_i[c], ov_fault_i[c]};
    assign faulty = (fv[c] != 4'h0) && (resp != RESP_CONTINUE);
    assign latched[c]  = st_reg[c] == CH_LATCHED;
    assign warn_any[c] = warn_i[c] || fv[c] != 4'h0;
    assign tmr_load = (st_reg[c] == CH_ON && faulty)
                   || (st_reg[c] == CH_OFF && req_on)
                   || (st_reg[c] == CH_LATCHED && !(ctrl_reg[CTRL_RETRY] && retry_reg[c] != rcnt));
    assign tmr_val  = st_reg[c] == CH_OFF ? (seq_mode == SEQ_TRACK ? 16'h0000 : ton_reg)
                    : st_reg[c] == CH_LATCHED ? restart_reg
                    : resp == RESP_SEQOFF ? toff_reg : DEGLITCH_RST;

    sfrm_timer #(.W(16)) u_tmr
    (
      .mclk_i  (mclk_i),
      .rst_b_i (rst_b_i),
      .load_i  (tmr_load),
      .value_i (tmr_val),
      .tick_i  (share_tick),
      .done_o  (tmr_done)
    );

    always_ff @(posedge mclk_i or negedge rst_b_i)
    begin
      if (!rst_b_i)
      begin
        st_reg[c]    <= CH_OFF;
        retry_reg[c] <= 3'h0;
        pg_reg[c]    <= 1'b0;
      end
      else if (por_reg)
      begin
        st_reg[c]    <= CH_OFF;
        retry_reg[c] <= 3'h0;
        pg_reg[c]    <= 1'b0;
      end
      else
      begin
        pg_reg[c] <= st_reg[c] == CH_ON && !faulty;
        unique case (st_reg[c])
          CH_OFF:
            if (req_on && prev_ok)
            begin
              st_reg[c]    <= CH_WAIT;
              retry_reg[c] <= 3'h0;
            end
          CH_WAIT:
            if (!req_on)
              st_reg[c] <= CH_OFF;
            else if (tmr_done && decayed)
              st_reg[c] <= CH_ON;
          CH_ON:
            if (!req_on)
              st_reg[c] <= CH_OFF;
            else if (faulty && (fv[c][F_OV] || fv[c][F_UV] || resp == RESP_IMMED))
              st_reg[c] <= CH_LATCHED;
            else if (faulty)
              st_reg[c] <= resp == RESP_SEQOFF ? CH_SEQOFF : CH_GLITCH;
            else if (pg_reg[c])
              retry_reg[c] <= 3'h0;
          CH_GLITCH:
            if (!faulty)
              st_reg[c] <= CH_ON;
            else if (tmr_done)
              st_reg[c] <= CH_LATCHED;
          CH_SEQOFF:
            if (tmr_done)
              st_reg[c] <= CH_LATCHED;
          CH_LATCHED:
            if (wr_clear && hwdata_i[c])
              st_reg[c] <= CH_OFF;
            else if (ctrl_reg[CTRL_RETRY] && retry_reg[c] != rcnt && tmr_done && decayed)
            begin
              st_reg[c] <= CH_WAIT;
              if (rcnt != RETRY_UNLIMITED)
                retry_reg[c] <= retry_reg[c] + 3'h1;
            end
          default:
            st_reg[c] <= CH_OFF;
        endcase
      end
    end

    always_ff @(posedge mclk_i or negedge rst_b_i)
    begin
      if (!rst_b_i)
        fault_log_req_o[c] <= 1'b0;
      else
        fault_log_req_o[c] <= st_reg[c] != CH_LATCHED && !por_reg
                              && ((st_reg[c] == CH_ON && faulty && (fv[c][1:0] != 2'h0
                                   || resp == RESP_IMMED))
                                  || ((st_reg[c] == CH_GLITCH || st_reg[c] == CH_SEQOFF)
                                      && faulty && tmr_done));
    end
  end

  assign status_w = {13'h0000, retry_reg[1], 5'h00, retry_reg[0],
                     por_reg, restore_busy_reg, pg_reg, 1'b0, wp_on, latched};

  // ----------------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      converter_en_o         <= 2'h0;
      power_good_out0_o      <= 1'b0;
      power_good_out1_o      <= 1'b0;
      shared_fault0_n_o      <= 1'b0;
      shared_fault0_n_oe_n_o <= 1'b1;
      shared_fault1_n_o      <= 1'b0;
      shared_fault1_n_oe_n_o <= 1'b1;
      aux_fault_out_n_o      <= 1'b0;
      aux_fault_out_n_oe_n_o <= 1'b1;
      irq_out_n_o            <= 1'b0;
      irq_out_n_oe_n_o       <= 1'b1;
      mcu_reset_n_o          <= 1'b1;
      por_active_o           <= 1'b0;
      serial_bus_enable_o    <= 1'b0;
      nvm_restore_req_o      <= 1'b0;
    end
    else
    begin
      for (int c = 0; c < 2; c++)
        converter_en_o[c] <= st_reg[c] == CH_ON || st_reg[c] == CH_GLITCH
                             || st_reg[c] == CH_SEQOFF;
      power_good_out0_o      <= pg_reg[0];
      power_good_out1_o      <= pg_reg[1];
      shared_fault0_n_oe_n_o <= !latched[0];
      shared_fault1_n_oe_n_o <= !latched[1];
      aux_fault_out_n_oe_n_o <= ((fv[0] & aux_a_reg & AUX_ALLOWED)
                                 | (fv[1] & aux_b_reg & AUX_ALLOWED)) == 4'h0;
      irq_out_n_oe_n_o       <= warn_any == 2'h0;
      mcu_reset_n_o          <= mcu_cnt_reg == 5'h00;
      por_active_o           <= por_reg;
      serial_bus_enable_o    <= !por_reg;
      nvm_restore_req_o      <= restore_busy_reg;
    end
  end
endmodule : sfrm_top
`default_nettype wire

// file: verification/sfrm_chk_sva.sv
// Port checker of the supply fault reset manager.
`timescale 1ns/1ps
`default_nettype none
module sfrm_chk
#(
  parameter int RESET_HOLD_CYC_P = 20
)
(
  input wire logic       mclk_i,
  input wire logic       rst_b_i,
  input wire logic       watchdog_kick_reset_n_i,
  input wire logic [1:0] ov_fault_i,
  input wire logic [1:0] uv_fault_i,
  input wire logic [1:0] ot_fault_i,
  input wire logic [1:0] warn_i,
  input wire logic [1:0] fault_log_req_o,
  input wire logic       shared_fault0_n_o,
  input wire logic       shared_fault0_n_oe_n_o,
  input wire logic [1:0] converter_en_o,
  input wire logic       aux_fault_out_n_oe_n_o,
  input wire logic       irq_out_n_oe_n_o,
  input wire logic       mcu_reset_n_o,
  input wire logic       por_active_o,
  input wire logic       serial_bus_enable_o,
  input wire logic       nvm_restore_req_o
);
  logic [15:0] low_reg;
  // Length of the present low level on the reset pin.
  always_ff @(posedge mclk_i or negedge rst_b_i)
    if (!rst_b_i)
      low_reg <= 16'h0000;
    else
      low_reg <= watchdog_kick_reset_n_i ? 16'h0000 : low_reg + 16'h0001;
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_b_i);
  aux_source_a:
    assert property (!aux_fault_out_n_oe_n_o |-> |(ov_fault_i | uv_fault_i
      | $past(ov_fault_i) | $past(uv_fault_i))) else $error("aux low, no fault");
  irq_raise_a:
    assert property ((|(ov_fault_i | uv_fault_i | ot_fault_i | warn_i))[*3]
      |-> !irq_out_n_oe_n_o) else $error("irq missing");
  por_quiet_a:
    assert property (por_active_o |-> !serial_bus_enable_o) else $error("bus live");
  log_pulse_a:
    assert property (fault_log_req_o[0] |=> !fault_log_req_o[0]) else $error("log long");
  por_hold_a:
    assert property ($rose(por_active_o) |-> low_reg >= RESET_HOLD_CYC_P)
      else $error("por early");
  mcu_pulse_a:
    assert property ($fell(mcu_reset_n_o) |-> (!mcu_reset_n_o)[*8] ##1
      (!mcu_reset_n_o)[*8] ##1 mcu_reset_n_o) else $error("mcu reset length");
  share_drive_a:
    assert property (!shared_fault0_n_oe_n_o |-> !shared_fault0_n_o && !converter_en_o[0])
      else $error("shared line drive wrong");
  por_exit_a:
    assert property ($fell(por_active_o) |-> $past(watchdog_kick_reset_n_i) ##[0:3]
      nvm_restore_req_o) else $error("no restore");
endmodule : sfrm_chk
bind sfrm_top sfrm_chk #(.RESET_HOLD_CYC_P(RESET_HOLD_CYC_P)) u_sfrm_chk (.*);
`default_nettype wire

// file: verification/sfrm_peer.sv
// Pulled-up shared fault lines, sync clock source and reset pin driver.
`timescale 1ns/1ps
`default_nettype none
module sfrm_peer
(
  input  wire logic       mclk_i,
  input  wire logic       hold_low_i,
  input  wire logic [1:0] oe_n_i,
  output wire logic [1:0] line_n_o,
  output wire logic       sync_o,
  output wire logic       kick_n_o
);
  logic [1:0] cnt_reg = 2'h0;
  // Open-drain lines read high unless pulled low.
  assign line_n_o = oe_n_i;
  assign sync_o = cnt_reg[1];
  assign kick_n_o = !hold_low_i;
  always @(posedge mclk_i)
    cnt_reg <= cnt_reg + 2'h1;
endmodule : sfrm_peer
`default_nettype wire

// file: verification/tb.sv
// Self-checking bench of the supply fault reset manager.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_mismatch++; \
  $display("unexpected %0t %h %h", $time, a, b); end end
`define W(c, n) begin i = 0; while (!(c) && i < n) begin @(posedge mclk_i); i++; end \
  if (!(c)) begin n_mismatch++; final_report(); end end
module tb;
  import sfrm_pkg::*;
  logic mclk_i = 1'h0, rst_b_i = 1'h0, hsel_i = 1'h0, hwrite_i = 1'h0, write_protect_i = 1'h0;
  logic hold = 1'h0, z = 1'h0, rdp = 1'h0;
  logic [1:0] htrans_i = 2'h0, ov_fault_i = 2'h0, uv_fault_i = 2'h0, ot_fault_i = 2'h0;
  logic [1:0] warn_i = 2'h0;
  logic [2:0] hsize_i = 3'h2;
  logic [31:0] haddr_i = 32'h0, hwdata_i = 32'h0, exp_v, rnd, q[$];
  int n_mismatch = 0, tests_run = 0, seed = 24850, i, n_log = 0, n_low = 0, m;
  wire logic [31:0] hrdata_o;
  wire logic [1:0] converter_en_o, fault_log_req_o;
  wire logic hreadyout_o, shared_fault0_n_i, shared_fault1_n_i, shared_fault0_n_oe_n_o;
  wire logic shared_fault1_n_oe_n_o, aux_fault_out_n_oe_n_o, irq_out_n_oe_n_o, mcu_reset_n_o;
  wire logic por_active_o, serial_bus_enable_o, nvm_restore_req_o, shared_sync_clock_i;
  wire logic watchdog_kick_reset_n_i, power_good_out0_o;
  sfrm_top #(.DEGLITCH_CYC_P(4), .RESET_HOLD_CYC_P(20)) u_sfrm_top (.*, .hready_i(hreadyout_o),
    .hresp_o(), .sequence_ctrl_in0_i(z), .sequence_ctrl_in1_i(z), .nvm_busy_i(z),
    .power_good_out1_o(), .shared_fault0_n_o(), .shared_fault1_n_o(),
    .aux_fault_out_n_o(), .irq_out_n_o());
  sfrm_peer u_sfrm_peer (.mclk_i, .hold_low_i(hold), .sync_o(shared_sync_clock_i),
    .oe_n_i({shared_fault1_n_oe_n_o, shared_fault0_n_oe_n_o}),
    .line_n_o({shared_fault1_n_i, shared_fault0_n_i}), .kick_n_o(watchdog_kick_reset_n_i));
  initial
  begin
    forever #50 mclk_i = ~mclk_i;
  end
  task automatic final_report();
    if (n_mismatch == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : final_report
  task automatic rdy();
    @(posedge mclk_i);
    `W(hreadyout_o === 1'h1, 20)
  endtask : rdy
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    hsel_i <= 1'h1;
    htrans_i <= 2'h2;
    hwrite_i <= w;
    haddr_i <= a;
    rdy();
    htrans_i <= 2'h0;
    hsel_i <= 1'h0;
    hwdata_i <= d;
    if (!w)
      q.push_back(d);
    rdy();
  endtask : bus
  task automatic kick(input int n);
    hold <= 1'h1;
    repeat (n) @(posedge mclk_i);
    hold <= 1'h0;
    repeat (60) @(posedge mclk_i);
  endtask : kick
  // Read data are compared in the cycle the wait state ends.
  always @(posedge mclk_i)
  begin
    if (fault_log_req_o[0] === 1'h1)
      n_log++;
    if (mcu_reset_n_o === 1'h0)
      n_low++;
    if (rdp && hreadyout_o === 1'h1)
    begin
      exp_v = q.pop_front();
      rdp = 1'h0;
      `CHK(hrdata_o, exp_v)
    end
    else if (hsel_i && htrans_i[1] && !hwrite_i && hreadyout_o === 1'h1)
      rdp = 1'h1;
  end
  initial
  begin
    repeat (4) @(posedge mclk_i);
    rst_b_i <= 1'h1;
    repeat (2) @(posedge mclk_i);
    `W(nvm_restore_req_o === 1'h0, 40)
    bus(1'h0, ADDR_CTRL, CTRL_RST);
    bus(1'h0, 32'h40, 32'h0);
    bus(1'h1, ADDR_AUXSEL_A, 32'hF);
    bus(1'h1, ADDR_RESP, 32'hA);
    bus(1'h1, ADDR_DECAY, 32'hFFFF_FFFF);
    bus(1'h1, ADDR_TON, 32'h2);
    bus(1'h1, ADDR_CTRL, 32'h3);
    `W(converter_en_o === 2'h3, 400)
    `CHK(irq_out_n_oe_n_o, 1'h1)
    warn_i <= 2'h2;
    repeat (2) @(posedge mclk_i);
    `CHK(irq_out_n_oe_n_o, 1'h0)
    `CHK(power_good_out0_o, 1'h1)
    ov_fault_i <= 2'h1;
    `W(converter_en_o[0] === 1'h0, 40)
    `CHK(aux_fault_out_n_oe_n_o, 1'h0)
    `CHK(shared_fault0_n_oe_n_o, 1'h0)
    ov_fault_i <= 2'h0;
    ot_fault_i <= 2'h1;
    warn_i <= 2'h2;
    repeat (3) @(posedge mclk_i);
    `CHK(aux_fault_out_n_oe_n_o, 1'h1)
    `CHK(irq_out_n_oe_n_o, 1'h0)
    `CHK(n_log, 1)
    ot_fault_i <= 2'h0;
    warn_i <= 2'h0;
    write_protect_i <= 1'h1;
    rnd = $random(seed) & 32'hFF;
    bus(1'h1, ADDR_TOFF, rnd);
    bus(1'h0, ADDR_TOFF, 32'h0);
    write_protect_i <= 1'h0;
    bus(1'h1, ADDR_TOFF, rnd);
    bus(1'h0, ADDR_TOFF, rnd);
    bus(1'h1, ADDR_WDOG, 32'h64);
    `W(mcu_reset_n_o === 1'h0, 200)
    `W(mcu_reset_n_o === 1'h1, 40)
    m = n_low;
    repeat (3) kick(6);
    `CHK(n_low, m)
    repeat (3) kick(3);
    `CHK(n_low > m, 1'h1)
    `CHK(por_active_o, 1'h0)
    hold <= 1'h1;
    `W(por_active_o === 1'h1, 60)
    `CHK(serial_bus_enable_o, 1'h0)
    bus(1'h0, ADDR_TOFF, 32'h0);
    hold <= 1'h0;
    `W(por_active_o === 1'h0, 40)
    repeat (2) @(posedge mclk_i);
    `W(nvm_restore_req_o === 1'h0, 40)
    bus(1'h0, ADDR_CTRL, CTRL_RST);
    final_report();
  end
endmodule : tb
`default_nettype wire
